/* include/pcr_pkg.sv */
// Package: register map, field layout and link constants for the config bank
package pcr_pkg;
  localparam logic [4:0]  ADDR_IDENT    = 5'h00;
  localparam logic [4:0]  ADDR_POWER    = 5'h01;
  localparam logic [4:0]  ADDR_REFDIV   = 5'h02;
  localparam logic [4:0]  ADDR_DIVWHOLE = 5'h03;
  localparam logic [4:0]  ADDR_DIVFINE  = 5'h04;
  localparam logic [4:0]  ADDR_OSCFWD   = 5'h05;
  localparam logic [4:0]  ADDR_LINKRATE = 5'h0a;
  // Identity value is arbitrary
  localparam logic [23:0] IDENT_VALUE   = 24'h0012_3456;
  localparam logic [23:0] POWER_RESET   = 24'h0000_0002;
  localparam logic [13:0] REFDIV_RESET  = 14'h0001;
  localparam logic [18:0] WHOLE_RESET   = 19'h0_0019;
  localparam logic [23:0] FINE_RESET    = 24'h0000_0000;
  localparam logic [15:0] FWD_RESET     = 16'h0000;
  localparam logic [18:0] WHOLE_MIN_FRAC = 19'h0_0014;
  localparam logic [18:0] WHOLE_MAX_FRAC = 19'h7_fffc;
  localparam logic [18:0] WHOLE_MIN_INT  = 19'h0_0010;
  localparam logic [13:0] REFDIV_MIN     = 14'h0001;
  localparam int SEL_LSB  = 0;
  localparam int ADR_LSB  = 3;
  localparam int PAY_LSB  = 7;
  localparam int RATE_LSB = 13;
  localparam int PKT_BITS = 16;
  localparam int SOFT_RST_BIT = 5;
  localparam int EN_SRC_BIT = 0;
  localparam int EN_REG_BIT = 1;
  localparam int HOLD_LSB   = 2;
  localparam logic [4:0] PKT_LAST = 5'h0f;
endpackage : pcr_pkg

/* src/pcr_rate_div.sv */
// Link bit-rate divider: one-cycle tick every 2^(rate+1) clocks
`timescale 1ns/1ns
`default_nettype none
module pcr_rate_div
  import pcr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [1:0] rate,
  output logic            tick
);
  logic [3:0] cnt_q;
  logic [3:0] lim;
  always_comb
  begin
    lim = 4'((4'h2 << rate) - 4'h1);
  end
  always_ff @(posedge clk)
  begin
    if (reset || !run || cnt_q == lim)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_q + 4'h1;
  end
  assign tick = run && (cnt_q == lim);
endmodule : pcr_rate_div
`default_nettype wire

/* src/pcr_link_tx.sv */
// Shifts one 16-bit packet MSB first on the internal oscillator link
`timescale 1ns/1ns
`default_nettype none
module pcr_link_tx
  import pcr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic [15:0] packet,
  input  wire logic        tick,
  output logic             busy,
  output logic             link_clk,
  output logic             link_data,
  output logic             link_frame
);
  logic [15:0] sh_q;
  logic [4:0]  cnt_q;
  logic        busy_q;
  logic        phase_q;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sh_q    <= 16'h0000;
      cnt_q   <= 5'h00;
      busy_q  <= 1'b0;
      phase_q <= 1'b0;
    end
    else if (start && !busy_q)
    begin
      sh_q    <= packet;
      cnt_q   <= 5'h00;
      busy_q  <= 1'b1;
      phase_q <= 1'b0;
    end
    else if (busy_q && tick)
    begin
      phase_q <= !phase_q;
      if (phase_q)
      begin
        sh_q <= {sh_q[14:0], 1'b0};
        if (cnt_q == PKT_LAST)
          busy_q <= 1'b0;
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end
  assign busy       = busy_q;
  assign link_clk   = phase_q;
  assign link_data  = sh_q[15];
  assign link_frame = busy_q;
endmodule : pcr_link_tx
`default_nettype wire

/* src/pcr_config_bank.sv */
// Config register bank of the synthesizer with indirect oscillator forwarding
`timescale 1ns/1ns
`default_nettype none
module pcr_config_bank
  import pcr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [4:0]  addr,
  input  wire logic [23:0] wdata,
  output logic [23:0]      rdata,
  output logic [4:0]       readback_addr,
  output logic             soft_reset,
  input  wire logic        cal_wr,
  input  wire logic [8:0]  cal_payload,
  input  wire logic        fractional_mode,
  input  wire logic        chip_enable_pin,
  output logic             synth_enable,
  output logic [5:0]       block_power,
  output logic [13:0]      ref_divide,
  output logic [18:0]      whole_divide,
  output logic [23:0]      fine_divide,
  output logic             whole_in_range,
  output logic             fwd_busy,
  output logic             link_clk,
  output logic             link_data,
  output logic             link_frame
);
  logic [23:0] power_q;
  logic [13:0] refdiv_q;
  logic [18:0] whole_q;
  logic [23:0] fine_q;
  logic [15:0] fwd_q;
  logic [15:0] pend_q;
  logic        pend_v_q;
  logic [1:0]  rate_q;
  logic [4:0]  rb_addr_q;
  logic        srst_q;
  logic        host_fwd;
  logic [15:0] host_pkt;
  logic [15:0] cal_pkt;
  logic        tx_busy;
  logic        tick;
  logic        launch;
  logic        pin_s1_q;
  logic        pin_s2_q;
  logic        en_pin_sel;
  logic        en_now;

  assign host_fwd = wr_en && addr == ADDR_OSCFWD;
  assign host_pkt = wdata[15:0];
  // Payload only; select and address stay as held
  assign cal_pkt  = {cal_payload, pend_v_q ? pend_q[6:0] : fwd_q[6:0]};

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      power_q  <= POWER_RESET;
      refdiv_q <= REFDIV_RESET;
      whole_q  <= WHOLE_RESET;
      fine_q   <= FINE_RESET;
      rate_q   <= 2'b00;
    end
    else if (wr_en)
    begin
      case (addr)
        ADDR_POWER:    power_q  <= wdata;
        ADDR_REFDIV:   refdiv_q <= wdata[13:0];
        ADDR_DIVWHOLE: whole_q  <= wdata[18:0];
        ADDR_DIVFINE:  fine_q   <= wdata;
        ADDR_LINKRATE: rate_q   <= wdata[RATE_LSB +: 2];
        default: ;
      endcase
    end
  end

  // Readback address and one-cycle soft reset strobe
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rb_addr_q <= 5'h00;
      srst_q    <= 1'b0;
    end
    else
    begin
      srst_q <= wr_en && addr == ADDR_IDENT && wdata[SOFT_RST_BIT];
      if (wr_en && addr == ADDR_IDENT)
        rb_addr_q <= wdata[4:0];
    end
  end

  // Pending slot: a write during a transfer waits, later write replaces it
  assign launch = pend_v_q && !tx_busy;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pend_q   <= FWD_RESET;
      pend_v_q <= 1'b0;
      fwd_q    <= FWD_RESET;
    end
    else
    begin
      if (host_fwd)
      begin
        pend_q   <= host_pkt;
        pend_v_q <= 1'b1;
      end
      else if (cal_wr)
      begin
        pend_q   <= cal_pkt;
        pend_v_q <= 1'b1;
      end
      else if (launch)
        pend_v_q <= 1'b0;
      if (launch)
        fwd_q <= pend_q;
    end
  end

  pcr_rate_div u_div (
    .clk   (clk),
    .reset (reset),
    .run   (tx_busy),
    .rate  (rate_q),
    .tick  (tick)
  );

  pcr_link_tx u_tx (
    .clk        (clk),
    .reset      (reset),
    .start      (launch),
    .packet     (pend_q),
    .tick       (tick),
    .busy       (tx_busy),
    .link_clk   (link_clk),
    .link_data  (link_data),
    .link_frame (link_frame)
  );

  // Pin is asynchronous to clk
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= chip_enable_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign en_pin_sel = power_q[EN_SRC_BIT];
  assign en_now = en_pin_sel ? pin_s2_q : power_q[EN_REG_BIT];

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      synth_enable <= 1'b1;
      block_power  <= 6'h3f;
    end
    else
    begin
      synth_enable <= en_now;
      block_power  <= en_now ? 6'h3f : power_q[HOLD_LSB +: 6];
    end
  end

  // Out-of-range values are flagged, not clamped
  always_ff @(posedge clk)
  begin
    if (reset)
      whole_in_range <= 1'b1;
    else if (fractional_mode)
      whole_in_range <= whole_q >= WHOLE_MIN_FRAC
                        && whole_q <= WHOLE_MAX_FRAC;
    else
      whole_in_range <= whole_q >= WHOLE_MIN_INT;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rdata <= 24'h0000_0000;
    else if (rd_en)
    begin
      case (addr)
        ADDR_IDENT:    rdata <= IDENT_VALUE;
        ADDR_POWER:    rdata <= power_q;
        ADDR_REFDIV:   rdata <= {10'h000, refdiv_q};
        ADDR_DIVWHOLE: rdata <= {5'h00, whole_q};
        ADDR_DIVFINE:  rdata <= fine_q;
        ADDR_OSCFWD:   rdata <= {8'h00, fwd_q};
        ADDR_LINKRATE: rdata <= {9'h000, rate_q, 13'h0000};
        default:       rdata <= 24'h0000_0000;
      endcase
    end
  end

  assign readback_addr = rb_addr_q;
  assign soft_reset    = srst_q;
  assign ref_divide    = refdiv_q;
  assign whole_divide  = whole_q;
  // Fine part contributes only in fractional mode
  assign fine_divide   = fractional_mode ? fine_q : 24'h0000_0000;
  assign fwd_busy      = tx_busy || pend_v_q;

  a_ident_read: assert property (@(posedge clk) disable iff (reset)
    rd_en && addr == ADDR_IDENT |=> rdata == IDENT_VALUE)
    else $error("identity read wrong");

  a_fwd_launch: assert property (@(posedge clk) disable iff (reset)
    host_fwd && !tx_busy && !pend_v_q |=> ##[0:1] link_frame)
    else $error("write did not launch transfer");

  a_cal_fields: assert property (@(posedge clk) disable iff (reset)
    cal_wr && !host_fwd && !pend_v_q |=> pend_q[6:0] == $past(fwd_q[6:0]))
    else $error("calibration altered select or address");

  a_msb_first: assert property (@(posedge clk) disable iff (reset)
    launch |=> link_data == $past(pend_q[15]))
    else $error("first bit not MSB");

  a_soft_strobe: assert property (@(posedge clk) disable iff (reset)
    wr_en && addr == ADDR_IDENT && wdata[SOFT_RST_BIT] |=> soft_reset
    ##1 !soft_reset || wr_en)
    else $error("soft reset strobe wrong");

  a_rb_store: assert property (@(posedge clk) disable iff (reset)
    wr_en && addr == ADDR_IDENT |=> readback_addr == $past(wdata[4:0]))
    else $error("readback address not stored");

  a_en_reg: assert property (@(posedge clk) disable iff (reset)
    !power_q[EN_SRC_BIT] && !$past(reset) |=> synth_enable
    == $past(power_q[EN_REG_BIT]))
    else $error("register enable not followed");

  a_hold_pwr: assert property (@(posedge clk) disable iff (reset)
    !en_now |=> block_power == $past(power_q[HOLD_LSB +: 6]))
    else $error("hold bits not applied");

  a_no_trunc: assert property (@(posedge clk) disable iff (reset)
    tx_busy && pend_v_q |=> pend_v_q)
    else $error("pending packet lost during transfer");
endmodule : pcr_config_bank
`default_nettype wire

/* testbench/pcr_osc_model.sv */
// Oscillator subsystem model at the far end of the internal link
`timescale 1ns/1ns
`default_nettype none
module pcr_osc_model
(
  input  wire logic   clk,
  input  wire logic   link_clk,
  input  wire logic   link_data,
  input  wire logic   link_frame,
  output logic [15:0] first_pkt,
  output logic [15:0] last_pkt,
  output int          pkt_count,
  output int          frame_len
);
  logic [15:0] shift_q;
  logic        frame_q;
  int          run_q;
  initial
  begin
    shift_q = 16'h0000;
    frame_q = 1'b0;
    run_q = 0;
    pkt_count = 0;
    frame_len = 0;
    first_pkt = 16'h0000;
    last_pkt = 16'h0000;
  end
  // Bits enter at the low end, so the first one ends up on top
  always @(posedge link_clk)
  begin
    if (link_frame)
      shift_q = {shift_q[14:0], link_data};
  end
  // Packet is taken when the frame drops, never part way through
  always @(posedge clk)
  begin
    if (link_frame)
      run_q = run_q + 1;
    if (frame_q && !link_frame)
    begin
      if (pkt_count == 0)
        first_pkt = shift_q;
      last_pkt = shift_q;
      pkt_count = pkt_count + 1;
      frame_len = run_q;
      run_q = 0;
    end
    frame_q = link_frame;
  end
endmodule : pcr_osc_model
`default_nettype wire

/* testbench/tb.sv */
// Testbench for the config register bank
`timescale 1ns/1ns
`default_nettype none
module tb;
  import pcr_pkg::*;
  logic        clk, reset, wr_en, rd_en, cal_wr;
  logic        fractional_mode, chip_enable_pin;
  logic [4:0]  addr;
  logic [23:0] wdata;
  logic [8:0]  cal_payload;
  logic [23:0] rdata, fine_divide;
  logic [4:0]  readback_addr;
  logic        soft_reset, synth_enable, whole_in_range, fwd_busy;
  logic [5:0]  block_power;
  logic [13:0] ref_divide;
  logic [18:0] whole_divide;
  logic        link_clk, link_data, link_frame;
  logic [15:0] first_pkt, last_pkt;
  int          pkt_count, frame_len;
  int          bad_count = 0;
  int          num_checks = 0;
  localparam logic [15:0] PKT_B = 16'h0ad8;
  logic [18:0] whole_v [7] = '{19'h0_0013, 19'h0_0014, 19'h7_fffc,
    19'h7_fffd, 19'h0_0010, 19'h0_000f, 19'h7_ffff};
  logic [6:0]  mode_v = 7'b000_1111;
  logic [6:0]  ok_v = 7'b101_0110;

  pcr_config_bank i_dut (.clk(clk), .reset(reset), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
    .readback_addr(readback_addr), .soft_reset(soft_reset),
    .cal_wr(cal_wr), .cal_payload(cal_payload),
    .fractional_mode(fractional_mode), .chip_enable_pin(chip_enable_pin),
    .synth_enable(synth_enable), .block_power(block_power),
    .ref_divide(ref_divide), .whole_divide(whole_divide),
    .fine_divide(fine_divide), .whole_in_range(whole_in_range),
    .fwd_busy(fwd_busy), .link_clk(link_clk), .link_data(link_data),
    .link_frame(link_frame));
  pcr_osc_model i_osc (.clk(clk), .link_clk(link_clk),
    .link_data(link_data), .link_frame(link_frame), .first_pkt(first_pkt),
    .last_pkt(last_pkt), .pkt_count(pkt_count), .frame_len(frame_len));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input string n, input logic [23:0] g,
                     input logic [23:0] e);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [23:0] e);
    @(negedge clk);
    rd_en = 1'b1;
    addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    chk("rdata", rdata, e);
  endtask : rd

  // Bounded waits: a hang counts as a mismatch and ends the run
  task automatic wait_en(input logic e);
    int n;
    n = 0;
    while (synth_enable !== e && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    if (synth_enable !== e)
    begin
      $display("CHECK FAILED synth_enable wait expected %b seen %b",
               e, synth_enable);
      bad_count++;
      wrap_up();
    end
    @(negedge clk);
    chk("synth_enable", {23'h0, synth_enable}, {23'h0, e});
  endtask : wait_en

  task automatic wait_idle;
    int n;
    n = 0;
    while (fwd_busy !== 1'b0 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    if (fwd_busy !== 1'b0)
    begin
      $display("CHECK FAILED fwd_busy expected 0 seen %b", fwd_busy);
      bad_count++;
      wrap_up();
    end
    // Far end takes the packet one edge after the frame drops
    repeat (2) @(negedge clk);
  endtask : wait_idle

  initial
  begin
    reset = 1'b1;
    {wr_en, rd_en, cal_wr, fractional_mode, chip_enable_pin} = 5'h00;
    addr = 5'h00;
    wdata = 24'h00_0000;
    cal_payload = 9'h000;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    chk("block_power", {18'h0, block_power}, 24'h00_003f);
    rd(ADDR_IDENT, IDENT_VALUE);
    rd(ADDR_POWER, 24'h00_0002);
    rd(ADDR_REFDIV, 24'h00_0001);
    rd(ADDR_DIVWHOLE, 24'h00_0019);
    rd(ADDR_DIVFINE, 24'h00_0000);
    rd(5'h1f, 24'h00_0000);
    $display("test reset_values done");
    wr(ADDR_IDENT, 24'h00_0023);
    chk("soft_reset", {23'h0, soft_reset}, 24'h00_0001);
    chk("readback", {19'h0, readback_addr}, 24'h00_0003);
    wr(ADDR_IDENT, 24'h00_0004);
    chk("soft_reset", {23'h0, soft_reset}, 24'h00_0000);
    chk("readback", {19'h0, readback_addr}, 24'h00_0004);
    rd(ADDR_IDENT, IDENT_VALUE);
    $display("test reg_zero done");
    wr(ADDR_POWER, 24'h00_00a4);
    wait_en(1'b0);
    chk("block_power", {18'h0, block_power}, 24'h00_0029);
    chip_enable_pin = 1'b1;
    wr(ADDR_POWER, 24'h00_0001);
    wait_en(1'b1);
    chip_enable_pin = 1'b0;
    wait_en(1'b0);
    wr(ADDR_POWER, 24'h00_0002);
    wait_en(1'b1);
    chk("block_power", {18'h0, block_power}, 24'h00_003f);
    $display("test power done");
    wr(5'h08, 24'h00_0008);
    wr(ADDR_REFDIV, 24'h00_3fff);
    rd(ADDR_REFDIV, 24'h00_3fff);
    chk("ref_divide", {10'h0, ref_divide}, 24'h00_3fff);
    for (int i = 0; i < 7; i++)
    begin
      fractional_mode = mode_v[i];
      wr(ADDR_DIVWHOLE, {5'h0, whole_v[i]});
      repeat (2) @(negedge clk);
      chk("in_range", {23'h0, whole_in_range}, {23'h0, ok_v[i]});
    end
    chk("whole_divide", {5'h0, whole_divide}, 24'h07_ffff);
    wr(ADDR_DIVFINE, 24'hab_cdef);
    repeat (2) @(negedge clk);
    chk("fine_int", fine_divide, 24'h00_0000);
    fractional_mode = 1'b1;
    repeat (2) @(negedge clk);
    chk("fine_frac", fine_divide, 24'hab_cdef);
    $display("test dividers done");
    wr(ADDR_LINKRATE, 24'h00_2000);
    wr(ADDR_OSCFWD, 24'hab_7f10);
    wr(ADDR_OSCFWD, {8'h00, PKT_B});
    wait_idle();
    chk("pkt_count", 24'(pkt_count), 24'h00_0002);
    chk("first_pkt", {8'h0, first_pkt}, 24'h00_7f10);
    chk("last_pkt", {8'h0, last_pkt}, {8'h0, PKT_B});
    chk("frame_ok", {23'h0, frame_len >= 124 && frame_len <= 132},
        24'h00_0001);
    rd(ADDR_OSCFWD, {8'h0, PKT_B});
    wr(ADDR_LINKRATE, 24'h00_0000);
    @(negedge clk);
    cal_payload = 9'h155;
    cal_wr = 1'b1;
    @(negedge clk);
    cal_wr = 1'b0;
    wait_idle();
    chk("cal_pkt", {8'h0, last_pkt}, {8'h0, 9'h155, PKT_B[6:0]});
    chk("frame_len", 24'(frame_len), 24'h00_0040);
    rd(ADDR_OSCFWD, {8'h0, 9'h155, PKT_B[6:0]});
    wr(ADDR_LINKRATE, 24'h00_6000);
    rd(ADDR_LINKRATE, 24'h00_6000);
    wr(ADDR_OSCFWD, 24'h00_7f00);
    wait_idle();
    chk("pkt_count", 24'(pkt_count), 24'h00_0004);
    chk("reset_pkt", {8'h0, last_pkt}, 24'h00_7f00);
    chk("frame_len", 24'(frame_len), 24'h00_0200);
    $display("test forwarding done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
